// >>> hw/spi_port_pkg.sv
// Package of constants and types for the two ends of the serial host port; the state type is the host's.
package spi_port_pkg;
	localparam int unsigned  WORD_W      = 8;
	localparam int unsigned  CNT_W       = 4;
	localparam logic [CNT_W-1:0] BIT_LAST = 4'h7;
	localparam logic [CNT_W-1:0] BIT_ZERO = 4'h0;
	localparam logic [WORD_W-1:0] WORD_ZERO = 8'h00;
	localparam int unsigned  CLK_MHZ     = 50;
	localparam int unsigned  SCLK_HALF_NS = 80;
	localparam logic [7:0]   SCLK_HALF_CYC = 8'((SCLK_HALF_NS * CLK_MHZ) / 1000);
	localparam logic [7:0]   HALF_ZERO   = 8'h00;
	localparam logic [7:0]   HALF_ONE    = 8'h01;
	// Command byte: bit 7 set means a read; host sends one command then one data byte.
	localparam int unsigned  RD_BIT      = 7;

	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_LEAD = 4'b0010,
		H_SHIFT = 4'b0100,
		H_TAIL = 4'b1000
	} host_state_t;
endpackage

// >>> hw/spi_link_if.sv
// Interface joining the serial host and the device port.
`timescale 1ns/1ps
interface spi_link_if;
	logic sclk;            // Serial clock from host.
	logic chip_select_n;   // Active-low select from host.
	logic sdi;             // Host to device data.
	logic so_out;          // Device data-out drive value.
	logic so_oe;           // Device data-out enable.
	wire  serial_out_irq_n = so_oe ? so_out : 1'b1; // Pulled high when released.

	modport device (
		input  sclk,
		input  chip_select_n,
		input  sdi,
		output so_out,
		output so_oe
	);
	modport host (
		output sclk,
		output chip_select_n,
		output sdi,
		input  serial_out_irq_n
	);
endinterface

// >>> hw/spi_device_port.sv
// Device end of the serial host port: shifts bytes in and read data out.
`timescale 1ns/1ps
module spi_device_port
	import spi_port_pkg::*;
(
	input  wire logic                       clock,      // System clock, 50 MHz.
	input  wire logic                       rst_n,      // Asynchronous reset, active low.
	spi_link_if.device                      link,       // Serial pins.
	input  wire logic [spi_port_pkg::WORD_W-1:0] rd_data, // Data returned on reads.
	input  wire logic                       irq_pend,   // Enabled interrupt pending.
	output logic [spi_port_pkg::WORD_W-1:0] cmd_byte,   // Last command byte.
	output logic                            cmd_valid,  // Pulse: command byte taken.
	output logic [spi_port_pkg::WORD_W-1:0] wr_data,    // Data byte of a write.
	output logic                            wr_valid    // Pulse: write data taken.
);
	import spi_port_pkg::*;

	typedef struct packed {
		logic [2:0]        sclk_s;
		logic [2:0]        csn_s;
		logic [1:0]        sdi_s;
		logic [CNT_W-1:0]  bitn;
		logic              second;
		logic              rd;
		logic [WORD_W-1:0] shin;
		logic [WORD_W-1:0] shout;
		logic              so_out;
		logic              so_oe;
		logic [WORD_W-1:0] cmd_byte;
		logic              cmd_valid;
		logic [WORD_W-1:0] wr_data;
		logic              wr_valid;
	} dev_t;

	dev_t r;
	dev_t next_r;
	logic sclk_rise;
	logic sclk_fall;
	logic csn;
	logic [WORD_W-1:0] byte_in;

	// Edge finding uses only the second and third synchroniser stages.
	assign sclk_rise = r.sclk_s[1] & ~r.sclk_s[2];
	assign sclk_fall = ~r.sclk_s[1] & r.sclk_s[2];
	assign csn       = r.csn_s[1];
	assign byte_in   = {r.shin[WORD_W-2:0], r.sdi_s[1]};

	// Next-state logic of the whole port.
	always_comb begin
		next_r = r;
		next_r.sclk_s = {r.sclk_s[1:0], link.sclk};
		next_r.csn_s = {r.csn_s[1:0], link.chip_select_n};
		next_r.sdi_s = {r.sdi_s[0], link.sdi};
		next_r.cmd_valid = 1'b0;
		next_r.wr_valid = 1'b0;
		if (csn) begin
			next_r.bitn = BIT_ZERO;
			next_r.second = 1'b0;
			next_r.rd = 1'b0;
			next_r.so_oe = 1'b0;
			next_r.so_out = 1'b1;
		end else begin
			next_r.so_oe = 1'b1;
			if (!r.so_oe) begin
				next_r.so_out = ~irq_pend;
			end
			if (sclk_rise) begin
				next_r.shin = byte_in;
				next_r.bitn = r.bitn + 4'h1;
				if (r.bitn == BIT_LAST) begin
					next_r.bitn = BIT_ZERO;
					if (!r.second) begin
						next_r.cmd_byte = byte_in;
						next_r.cmd_valid = 1'b1;
						next_r.second = 1'b1;
						next_r.rd = byte_in[RD_BIT];
						next_r.shout = rd_data;
					end else begin
						if (!r.rd) begin
							next_r.wr_data = byte_in;
							next_r.wr_valid = 1'b1;
						end
						next_r.second = 1'b0;
						next_r.rd = 1'b0;
					end
				end
			end
			if (sclk_fall) begin
				if (r.rd) begin
					next_r.so_out = r.shout[WORD_W-1];
					next_r.shout = {r.shout[WORD_W-2:0], 1'b0};
				end else begin
					next_r.so_out = ~irq_pend;
				end
			end
		end
	end

	// State register.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{sclk_s: 3'h0, csn_s: 3'h7, sdi_s: 2'h0, bitn: BIT_ZERO, second: 1'b0,
				rd: 1'b0, shin: WORD_ZERO, shout: WORD_ZERO, so_out: 1'b1, so_oe: 1'b0,
				cmd_byte: WORD_ZERO, cmd_valid: 1'b0, wr_data: WORD_ZERO, wr_valid: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign link.so_out = r.so_out;
	assign link.so_oe  = r.so_oe;
	assign cmd_byte    = r.cmd_byte;
	assign cmd_valid   = r.cmd_valid;
	assign wr_data     = r.wr_data;
	assign wr_valid    = r.wr_valid;
endmodule

// >>> hw/spi_host_port.sv
// Host end of the serial port: runs one two-byte frame per request.
`timescale 1ns/1ps
module spi_host_port
	import spi_port_pkg::*;
(
	input  wire logic                       clock,     // System clock, 50 MHz.
	input  wire logic                       rst_n,     // Asynchronous reset, active low.
	spi_link_if.host                        link,      // Serial pins.
	input  wire logic                       start,     // Pulse: begin a frame.
	input  wire logic [spi_port_pkg::WORD_W-1:0] cmd,  // Command byte, bit 7 read.
	input  wire logic [spi_port_pkg::WORD_W-1:0] wdata, // Write data byte.
	output logic                            busy,      // Frame in progress.
	output logic                            done,      // Pulse: frame finished.
	output logic [spi_port_pkg::WORD_W-1:0] rdata,     // Byte read back.
	output logic                            irq_seen   // Interrupt level seen while selected.
);
	import spi_port_pkg::*;

	typedef struct packed {
		host_state_t       st;
		logic [7:0]        half;
		logic [CNT_W-1:0]  bitn;
		logic              second;
		logic [WORD_W-1:0] shout;
		logic [WORD_W-1:0] shin;
		logic              sclk;
		logic              csn;
		logic [1:0]        so_s;
		logic              busy;
		logic              done;
		logic [WORD_W-1:0] rdata;
		logic              irq_seen;
	} host_t;

	host_t r;
	host_t next_r;
	logic tick;

	assign tick = (r.half == HALF_ONE);

	// Frame sequencer; clock divided from the system clock.
	always_comb begin
		next_r = r;
		next_r.so_s = {r.so_s[0], link.serial_out_irq_n};
		next_r.done = 1'b0;
		next_r.half = tick ? SCLK_HALF_CYC : r.half - 8'h01;
		case (r.st)
			H_IDLE: begin
				next_r.csn = 1'b1;
				next_r.sclk = 1'b0;
				if (start) begin
					next_r.st = H_LEAD;
					next_r.csn = 1'b0;
					next_r.busy = 1'b1;
					next_r.shout = cmd;
					next_r.second = 1'b0;
					next_r.bitn = BIT_ZERO;
					next_r.half = SCLK_HALF_CYC;
				end
			end
			H_LEAD: begin
				if (tick) begin
					next_r.st = H_SHIFT;
				end
			end
			H_SHIFT: begin
				if (tick) begin
					next_r.sclk = ~r.sclk;
					if (r.sclk) begin
						// Data-out is read at the end of the high half. The device answers a
						// fall only after its synchroniser, and with the host synchroniser that takes longer than half a period.
						next_r.shin = {r.shin[WORD_W-2:0], r.so_s[1]};
						if (r.bitn == BIT_ZERO && !r.second) begin
							next_r.irq_seen = ~r.so_s[1];
						end
						next_r.shout = {r.shout[WORD_W-2:0], 1'b0};
						next_r.bitn = r.bitn + 4'h1;
						if (r.bitn == BIT_LAST) begin
							next_r.bitn = BIT_ZERO;
							if (!r.second) begin
								next_r.second = 1'b1;
								next_r.shout = wdata;
							end else begin
								next_r.st = H_TAIL;
							end
						end
					end
				end
			end
			H_TAIL: begin
				if (tick) begin
					next_r.st = H_IDLE;
					next_r.csn = 1'b1;
					next_r.busy = 1'b0;
					next_r.done = 1'b1;
					next_r.rdata = r.shin;
				end
			end
			default: begin
				next_r.st = H_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{st: H_IDLE, half: HALF_ZERO, bitn: BIT_ZERO, second: 1'b0,
				shout: WORD_ZERO, shin: WORD_ZERO, sclk: 1'b0, csn: 1'b1, so_s: 2'h3,
				busy: 1'b0, done: 1'b0, rdata: WORD_ZERO, irq_seen: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign link.sclk          = r.sclk;
	assign link.chip_select_n = r.csn;
	assign link.sdi           = r.shout[WORD_W-1];
	assign busy               = r.busy;
	assign done               = r.done;
	assign rdata              = r.rdata;
	assign irq_seen           = r.irq_seen;
endmodule

// >>> test/spi_link_sva.sv
// Checker of the serial link wires between the host and device ends.
`timescale 1ns/1ps
module spi_link_sva (
	input wire logic clock,            // System clock.
	input wire logic rst_n,            // Reset, active low.
	input wire logic sclk,             // Serial clock.
	input wire logic chip_select_n,    // Select, active low.
	input wire logic sdi,              // Host data.
	input wire logic so_out,           // Device drive value.
	input wire logic so_oe,            // Device drive enable.
	input wire logic serial_out_irq_n  // Shared data-out and interrupt line.
);
	logic [4:0] rises;   // Serial clock rises in this frame.
	logic       sclk_q;  // Serial clock one cycle back.

	// Counts rising serial edges while selected and clears when deselected.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rises <= 5'h00;
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk;
			rises <= chip_select_n ? 5'h00 : rises + 5'(sclk && !sclk_q);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence frame_open;
		$fell(chip_select_n);
	endsequence
	sequence frame_close;
		$rose(chip_select_n);
	endsequence

	a_frame_sixteen_rises: assert property (frame_close |-> rises == 5'h10)
		else $error("frame did not hold sixteen serial clock rises");
	a_sclk_idle_low: assert property (chip_select_n |-> !sclk)
		else $error("serial clock not low while deselected");
	a_drive_needs_select: assert property ($rose(so_oe) |-> !chip_select_n)
		else $error("data-out driven without select");
	a_release_when_idle: assert property (chip_select_n [*6] |-> !so_oe)
		else $error("data-out still driven after deselect");
	a_drive_after_select: assert property (frame_open |-> ##[1:6] so_oe)
		else $error("line not driven after select");
	a_select_held: assert property (frame_open |-> !chip_select_n [*8])
		else $error("select not held low");
	a_line_steady_rise: assert property ($rose(sclk) && so_oe |-> $stable(serial_out_irq_n))
		else $error("data-out changed at serial clock rise");
	a_sdi_steady_rise: assert property ($rose(sclk) |-> $stable(sdi))
		else $error("data-in changed at serial clock rise");
	a_out_steady_high: assert property (so_oe && sclk && $past(sclk) |-> $stable(so_out))
		else $error("data-out changed while serial clock high");
endmodule

// >>> test/adc_serial_port_frontend_bench.sv
// Bench that joins the host and device ends and checks whole frames.
`timescale 1ns/1ps
module adc_serial_port_frontend_bench;
	import spi_port_pkg::*;
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] wdata;
		logic [7:0] rd;
		logic       irq;
	} row_t;
	logic       clock, rst_n, host_rst_n, start, irq_pend, busy, done, irq_seen;
	logic [7:0] cmd, wdata, rd_data, rdata, cmd_byte, wr_data;
	logic       cmd_valid, wr_valid;
	int         bad_count = 0, cmp_count = 0, cycles = 0, cmd_n = 0, wr_n = 0;
	row_t       rows [4] = '{'{8'h05, 8'hA5, 8'h00, 1'b1}, '{8'h7F, 8'h5A, 8'hFF, 1'b0},
		'{8'h80, 8'h00, 8'h3C, 1'b1}, '{8'hFF, 8'hFF, 8'hC3, 1'b0}};

	spi_link_if link ();
	spi_host_port spi_host_port_inst (.clock(clock), .rst_n(rst_n & host_rst_n), .link(link),
		.start(start), .cmd(cmd), .wdata(wdata), .busy(busy), .done(done), .rdata(rdata),
		.irq_seen(irq_seen));
	spi_device_port spi_device_port_inst (.clock(clock), .rst_n(rst_n), .link(link),
		.rd_data(rd_data), .irq_pend(irq_pend), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
		.wr_data(wr_data), .wr_valid(wr_valid));
	spi_link_sva spi_link_sva_inst (.clock(clock), .rst_n(rst_n & host_rst_n),
		.sclk(link.sclk), .chip_select_n(link.chip_select_n), .sdi(link.sdi),
		.so_out(link.so_out), .so_oe(link.so_oe), .serial_out_irq_n(link.serial_out_irq_n));

	// Makes the 50 MHz clock.
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// Counts device pulses and cuts a hang short.
	always @(posedge clock) begin
		cycles++;
		if (cmd_valid === 1'b1) cmd_n++;
		if (wr_valid === 1'b1) wr_n++;
		if (cycles == 5000) begin
			bad_count++;
			results();
		end
	end

	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Runs one frame; with poke set a second start is sent while busy, or the host is
	// reset for one cycle in the data byte when abort is set.
	task automatic frame(input row_t r, input bit poke, input bit abort);
		int n;
		@(negedge clock);
		cmd = r.cmd;
		wdata = r.wdata;
		rd_data = r.rd;
		irq_pend = r.irq;
		start = 1'b1;
		n = 0;
		while (done !== 1'b1 && n < 400 && !(abort && n > 101)) begin
			@(negedge clock);
			start = poke && n == 30;
			host_rst_n = !(abort && n == 100);
			n++;
		end
		if (!abort) chk1("done", 1'b1, done);
		repeat (12) @(negedge clock);
	endtask

	task automatic results;
		$display("counts: %0d compared, %0d unexpected", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		host_rst_n = 1'b1;
		start = 1'b0;
		cmd = 8'h00;
		wdata = 8'h00;
		rd_data = 8'h00;
		irq_pend = 1'b0;
		repeat (12) @(negedge clock);
		chk1("so_oe", 1'b0, link.so_oe);
		chk1("line", 1'b1, link.serial_out_irq_n);
		chk1("busy", 1'b0, busy);
		rst_n = 1'b1;
		$display("test reset done");
		foreach (rows[i]) begin
			frame(rows[i], 1'b0, 1'b0);
			chk8("cmd_byte", rows[i].cmd, cmd_byte);
			if (rows[i].cmd[RD_BIT]) chk8("rdata", rows[i].rd, rdata);
			else chk8("wr_data", rows[i].wdata, wr_data);
			chk1("irq_seen", rows[i].irq, irq_seen);
			$display("test row %0d done", i);
		end
		chk8("cmd pulses", 8'h04, 8'(cmd_n));
		frame('{8'h11, 8'h66, 8'h00, 1'b0}, 1'b1, 1'b0);
		chk8("cmd_byte", 8'h11, cmd_byte);
		chk8("cmd pulses", 8'h05, 8'(cmd_n));
		$display("test start while busy done");
		wr_n = 0;
		frame('{8'h22, 8'h99, 8'h00, 1'b0}, 1'b0, 1'b1);
		chk8("wr pulses", 8'h00, 8'(wr_n));
		chk8("wr_data", 8'h66, wr_data);
		chk1("busy", 1'b0, busy);
		frame('{8'h33, 8'hC6, 8'h00, 1'b1}, 1'b0, 1'b0);
		chk8("wr_data", 8'hC6, wr_data);
		chk8("cmd_byte", 8'h33, cmd_byte);
		$display("test abort done");
		results();
	end
endmodule
